//--- hw/ccpc_map.svh
// Purpose: Register offsets, field positions, reset values and counts of the clock/port control.
// Assumes: APB byte addresses are four times the printed register index.
// Notes: Definitions only.
`ifndef CCPC_MAP_SVH
`define CCPC_MAP_SVH
// ****************************************
// Register indices and APB address width
// ****************************************
`define CCPC_IDX_IFACE_FORMAT 8'h04
`define CCPC_IDX_MISC 8'h05
`define CCPC_IDX_CLOCK 8'h06
`define CCPC_IDX_RATIO 8'h07
`define CCPC_IDX_RX_STATUS 8'h08
`define CCPC_IDX_PENDING 8'h0F
`define CCPC_IDX_LIVE 8'h10
`define CCPC_IDX_PLL_STATUS 8'h11
`define CCPC_ADDR_W 12
// ****************************************
// Field positions
// ****************************************
`define CCPC_FMT_AUX_RJ16 1
`define CCPC_FMT_MAIN_RJ16 0
`define CCPC_MISC_EXT_ADC_SEL 7
`define CCPC_MISC_TRISTATE 6
`define CCPC_MISC_RESERVED 5
`define CCPC_MISC_UPDATE_HOLD 4
`define CCPC_MISC_ROLLOFF 3
`define CCPC_MISC_HP_HOLD 2
`define CCPC_MISC_MAIN_MASTER 1
`define CCPC_MISC_AUX_MASTER 0
`define CCPC_CLK_FORCE_LOCK 0
`define CCPC_CLK_FRAME_LOCK 3
`define CCPC_RX_SILENCE 7
`define CCPC_RX_ACTIVE_CLK 3
// ****************************************
// Reset values and counts
// ****************************************
`define CCPC_RST_FORMAT 8'h40
`define CCPC_RST_MISC 8'h00
`define CCPC_RST_CLOCK 8'h00
`define CCPC_RST_PENDING 8'h00
`define CCPC_SILENCE_COUNT 11'h060C
`define CCPC_RANGE_FORCED 3'h7
`endif

//--- hw/ccpc_pkg.sv
// Purpose: Types of the clock and port control block.
// Assumes: Constants live in ccpc_map.svh.
// Notes: Policy and divider codes follow the clock control register.
package ccpc_pkg;
	typedef enum logic [1:0] {CCPC_POL_PLL, CCPC_POL_OSC, CCPC_POL_HOLD, CCPC_POL_AUTO} ccpc_policy_t;
	typedef enum logic [1:0] {CCPC_DIV1, CCPC_DIV2, CCPC_DIV4, CCPC_MUL2} ccpc_div_t;
	typedef logic [7:0] ccpc_byte_t;
endpackage : ccpc_pkg

//--- hw/ccpc_clk_sel.sv
// Purpose: Master clock source choice and recovered clock scaling, as levels sampled on core_clk.
// Assumes: Lock and clock phase inputs are already synchronous.
// Notes: Clock outputs are sampled waveforms; times two uses both phases of the reference.
`include "ccpc_map.svh"
module ccpc_clk_sel (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire ccpc_pkg::ccpc_policy_t clock_source_policy,
	input wire ccpc_pkg::ccpc_div_t recovered_clock_divider,
	input wire logic forced_pll_lock,
	input wire logic pll_locked,
	input wire logic pll_clk_level,
	input wire logic osc_clk_level,
	output logic use_osc,
	output logic mclk_level,
	output logic recovered_level
);
	import ccpc_pkg::*;
	logic next_use_osc;
	logic [1:0] div_cnt;
	logic [1:0] next_div_cnt;
	logic prev_mclk;
	logic next_recovered;
	logic ref_level;
	// ****************************************
	// Source policy
	// ****************************************
	always_comb begin
		case (clock_source_policy)
			CCPC_POL_PLL: next_use_osc = 1'b0;
			CCPC_POL_OSC: next_use_osc = 1'b1;
			CCPC_POL_HOLD: next_use_osc = use_osc | ~pll_locked;
			CCPC_POL_AUTO: next_use_osc = ~pll_locked;
			default: next_use_osc = 1'b0;
		endcase
	end
	// Forced lock never falls back; manual PLL with lost lock feeds the oscillator out
	assign ref_level = (forced_pll_lock | (~use_osc & pll_locked)) ? pll_clk_level :
		osc_clk_level;
	assign mclk_level = use_osc ? osc_clk_level : pll_clk_level;
	// Divider counts rising edges of the reference
	// Times two is a one-cycle pulse at each reference edge, so two pulses per period
	always_comb begin
		next_div_cnt = div_cnt;
		if (ref_level & ~prev_mclk) begin
			next_div_cnt = div_cnt + 2'h1;
		end
		case (recovered_clock_divider)
			CCPC_DIV1: next_recovered = ref_level;
			CCPC_DIV2: next_recovered = next_div_cnt[0];
			CCPC_DIV4: next_recovered = next_div_cnt[1];
			CCPC_MUL2: next_recovered = ref_level ^ prev_mclk;
			default: next_recovered = ref_level;
		endcase
	end
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			use_osc <= 1'b0;
			div_cnt <= 2'h0;
			prev_mclk <= 1'b0;
			recovered_level <= 1'b0;
		end else begin
			use_osc <= next_use_osc;
			div_cnt <= next_div_cnt;
			prev_mclk <= ref_level;
			recovered_level <= next_recovered;
		end
	end
endmodule : ccpc_clk_sel

//--- hw/ccpc_silence.sv
// Purpose: Counts consecutive zero samples from the digital audio input.
// Assumes: sample_valid is a one-cycle pulse on core_clk.
// Notes: Counter saturates, so silence stays flagged until a non-zero sample.
`include "ccpc_map.svh"
module ccpc_silence (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic sample_valid,
	input wire logic [23:0] sample_data,
	output logic silence
);
	logic [10:0] zero_cnt;
	logic [10:0] next_zero_cnt;
	// Count zeros, any other value restarts
	always_comb begin
		next_zero_cnt = zero_cnt;
		if (sample_valid) begin
			if (sample_data != 24'h00_0000) begin
				next_zero_cnt = 11'h000;
			end else if (zero_cnt != `CCPC_SILENCE_COUNT) begin
				next_zero_cnt = zero_cnt + 11'h001;
			end
		end
	end
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			zero_cnt <= 11'h000;
		end else begin
			zero_cnt <= next_zero_cnt;
		end
	end
	assign silence = (zero_cnt == `CCPC_SILENCE_COUNT);
endmodule : ccpc_silence

//--- hw/ccpc_top.sv
// Purpose: Codec clock and serial port control with APB register access.
// Assumes: PLL lock, ratio and range arrive from the receiver; pins pass a 3-stage sync.
// Notes: Output enables are active low while the block drives a pin.
//
// Decided for this implementation: the APB interface to the registers.
`include "ccpc_map.svh"

// Functional notes
// - Aux port right-justified words are 24 bits at 0, 16 bits at 1.
// - Main port right-justified DAC/ADC words are 24 bits at 0, 16 at 1.
// - External ADC bit clock comes from aux port at 0, main port at 1.
// - Tristate bit releases the recovered master clock pin.
// - Update hold stores held-register writes and applies them together on release.
// - Roll-off select 0 gives fast filter, 1 gives slow filter.
// - High-pass hold freezes the DC offset estimate, still subtracted.
// - Master ports drive divided bit and frame clocks; slave ports take them in.
// - Recovered clock divider: 00 /1, 01 /2, 10 /4, 11 x2.
// - Frame-lock select makes the PLL lock to the aux frame clock.
// - Policy: 00 PLL, 01 oscillator, 10 hold then oscillator, 11 auto.
// - Policy 00 with lost lock puts the oscillator on the recovered clock.
// - Under forced lock, lost lock never moves the recovered clock to the oscillator; the master clock still follows the policy.
// - Ratio register: two integer bits 7:6, six fraction bits 5:0.
// - Silence flag is set after 1548 consecutive zero input samples.
// - Active clock status reads 0 for PLL, 1 for oscillator.
module ccpc_top (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`CCPC_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic pll_locked,
	input wire logic pll_clk_level,
	input wire logic osc_clk_level,
	input wire logic [7:0] pll_ratio_meas,
	input wire logic [2:0] pll_range_meas,
	input wire logic audio_valid,
	input wire logic [23:0] audio_data,
	input wire logic main_bit_clock_in,
	input wire logic main_frame_clock_in,
	input wire logic aux_bit_clock_in,
	input wire logic aux_frame_clock_in,
	output logic main_bit_clock_out,
	output logic main_bit_clock_oe_n,
	output logic main_frame_clock_out,
	output logic main_frame_clock_oe_n,
	output logic aux_bit_clock_out,
	output logic aux_bit_clock_oe_n,
	output logic aux_frame_clock_out,
	output logic aux_frame_clock_oe_n,
	output logic ext_adc_bit_clock,
	output logic recovered_master_clock_out,
	output logic recovered_master_clock_oe_n,
	output logic [4:0] aux_word_bits,
	output logic [4:0] main_word_bits,
	output logic interp_rolloff_sel,
	output logic highpass_hold,
	output logic pll_frame_lock_sel,
	output logic [1:0] osc_clock_range,
	output logic autodetect_en,
	output ccpc_pkg::ccpc_byte_t held_settings
);
	import ccpc_pkg::*;

	// ****************************************
	// Register state
	// ****************************************
	ccpc_byte_t fmt_reg;
	ccpc_byte_t next_fmt_reg;
	ccpc_byte_t misc_reg;
	ccpc_byte_t next_misc_reg;
	ccpc_byte_t clock_reg;
	ccpc_byte_t next_clock_reg;
	ccpc_byte_t pending_reg;
	ccpc_byte_t next_pending_reg;
	ccpc_byte_t next_held;
	logic [31:0] next_prdata;

	// Bus decode
	logic [7:0] idx;
	logic access;
	logic hit;

	// Clock choice and silence detection
	logic use_osc;
	logic mclk_level;
	logic recovered_level;
	logic silence;

	// Pin synchronisers and shared port divider
	logic [2:0] pin_sync [4];
	logic [3:0] pin_clean;
	logic [3:0] pin_raw;
	logic [3:0] pin_hold;
	logic [3:0] next_pin_hold;
	logic [5:0] port_div;
	logic [5:0] next_port_div;
	logic mclk_prev;

	// ****************************************
	// Bus decode
	// ****************************************
	// Register index decoding used for reads and writes
	function automatic logic idx_mapped(input logic [7:0] i);
		idx_mapped = (i == `CCPC_IDX_IFACE_FORMAT) ||
			(i == `CCPC_IDX_MISC) ||
			(i == `CCPC_IDX_CLOCK) ||
			(i == `CCPC_IDX_RATIO) ||
			(i == `CCPC_IDX_RX_STATUS) ||
			(i == `CCPC_IDX_PENDING) ||
			(i == `CCPC_IDX_LIVE) ||
			(i == `CCPC_IDX_PLL_STATUS);
	endfunction : idx_mapped

	// Word index; unused address bits must be zero for a hit
	assign idx = paddr[9:2];
	assign access = psel & penable;
	assign hit = idx_mapped(idx) && (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);

	// Zero wait states; unmapped addresses answer with an error
	assign pready = 1'b1;
	assign pslverr = access & ~hit;

	// ****************************************
	// Register writes
	// ****************************************
	always_comb begin
		next_fmt_reg = fmt_reg;
		next_misc_reg = misc_reg;
		next_clock_reg = clock_reg;
		next_pending_reg = pending_reg;
		if (access && pwrite && hit && pstrb[0]) begin
			case (idx)
				`CCPC_IDX_IFACE_FORMAT: next_fmt_reg = pwdata[7:0];
				`CCPC_IDX_MISC: next_misc_reg = pwdata[7:0] & ~(8'h01 << `CCPC_MISC_RESERVED);
				`CCPC_IDX_CLOCK: next_clock_reg = pwdata[7:0];
				`CCPC_IDX_PENDING: next_pending_reg = pwdata[7:0];
				default: next_fmt_reg = fmt_reg;
			endcase
		end
		// Held settings reach the datapath only while the hold bit is clear
		next_held = misc_reg[`CCPC_MISC_UPDATE_HOLD] ? held_settings : pending_reg;
	end

	// ****************************************
	// Read data
	// ****************************************
	// Read mux; ratio invalid under forced lock reads zero
	always_comb begin
		next_prdata = 32'h0000_0000;
		if (psel && !penable && !pwrite) begin
			case (idx)
				`CCPC_IDX_IFACE_FORMAT: next_prdata[7:0] = fmt_reg;
				`CCPC_IDX_MISC: next_prdata[7:0] = misc_reg;
				`CCPC_IDX_CLOCK: next_prdata[7:0] = clock_reg;
				`CCPC_IDX_RATIO: next_prdata[7:0] = clock_reg[`CCPC_CLK_FORCE_LOCK] ? 8'h00 :
					pll_ratio_meas;
				`CCPC_IDX_RX_STATUS: begin
					next_prdata[`CCPC_RX_SILENCE] = silence;
					next_prdata[`CCPC_RX_ACTIVE_CLK] = use_osc;
					next_prdata[2:0] = clock_reg[`CCPC_CLK_FORCE_LOCK] ? `CCPC_RANGE_FORCED :
						pll_range_meas;
				end
				`CCPC_IDX_PENDING: next_prdata[7:0] = pending_reg;
				`CCPC_IDX_LIVE: next_prdata[7:0] = held_settings;
				`CCPC_IDX_PLL_STATUS: next_prdata[0] = pll_locked;
				default: next_prdata = 32'h0000_0000;
			endcase
		end else begin
			next_prdata = prdata;
		end
	end

	// Register update; reset loads the default of each field
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			fmt_reg <= `CCPC_RST_FORMAT;
			misc_reg <= `CCPC_RST_MISC;
			clock_reg <= `CCPC_RST_CLOCK;
			pending_reg <= `CCPC_RST_PENDING;
			held_settings <= `CCPC_RST_PENDING;
			prdata <= 32'h0000_0000;
		end else begin
			fmt_reg <= next_fmt_reg;
			misc_reg <= next_misc_reg;
			clock_reg <= next_clock_reg;
			pending_reg <= next_pending_reg;
			held_settings <= next_held;
			prdata <= next_prdata;
		end
	end

	// ****************************************
	// Static controls
	// ****************************************
	assign aux_word_bits = fmt_reg[`CCPC_FMT_AUX_RJ16] ? 5'd16 : 5'd24;
	assign main_word_bits = fmt_reg[`CCPC_FMT_MAIN_RJ16] ? 5'd16 : 5'd24;
	assign interp_rolloff_sel = misc_reg[`CCPC_MISC_ROLLOFF];
	assign highpass_hold = misc_reg[`CCPC_MISC_HP_HOLD];
	assign pll_frame_lock_sel = clock_reg[`CCPC_CLK_FRAME_LOCK];
	assign osc_clock_range = clock_reg[5:4];
	assign autodetect_en = ~clock_reg[`CCPC_CLK_FORCE_LOCK];

	// ****************************************
	// Pin synchronisers
	// ****************************************
	// Pin order, low bit first: main bit, main frame, aux bit, aux frame
	assign pin_raw = {aux_frame_clock_in, aux_bit_clock_in, main_frame_clock_in, main_bit_clock_in};

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_sync
			// Three stages; only the second stage reads the first
			always_ff @(posedge core_clk or negedge arst_n) begin
				if (!arst_n) begin
					pin_sync[g] <= 3'h0;
				end else begin
					pin_sync[g] <= {pin_sync[g][1:0], pin_raw[g]};
				end
			end
			// Change accepted when stages two and three agree
			assign next_pin_hold[g] = (pin_sync[g][1] == pin_sync[g][2]) ? pin_sync[g][2] :
				pin_hold[g];
			assign pin_clean[g] = pin_hold[g];
		end
	endgenerate

	// ****************************************
	// Port clock generation
	// ****************************************
	// Rising edges of the master clock step the shared port divider
	always_comb begin
		next_port_div = port_div;
		if (mclk_level && !mclk_prev) begin
			next_port_div = port_div + 6'h01;
		end
	end

	// Port clocks and pin hold stage; every pin drive comes from a flip-flop
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			port_div <= 6'h00;
			mclk_prev <= 1'b0;
			pin_hold <= 4'h0;
			main_bit_clock_out <= 1'b0;
			main_frame_clock_out <= 1'b0;
			aux_bit_clock_out <= 1'b0;
			aux_frame_clock_out <= 1'b0;
			ext_adc_bit_clock <= 1'b0;
			recovered_master_clock_out <= 1'b0;
		end else begin
			port_div <= next_port_div;
			mclk_prev <= mclk_level;
			pin_hold <= next_pin_hold;
			// Bit clock MCLK/4, frame clock MCLK/64 in master mode
			main_bit_clock_out <= port_div[1];
			main_frame_clock_out <= port_div[5];
			aux_bit_clock_out <= port_div[1];
			aux_frame_clock_out <= port_div[5];
			ext_adc_bit_clock <= misc_reg[`CCPC_MISC_EXT_ADC_SEL] ?
				(misc_reg[`CCPC_MISC_MAIN_MASTER] ? port_div[1] : pin_clean[0]) :
				(misc_reg[`CCPC_MISC_AUX_MASTER] ? port_div[1] : pin_clean[2]);
			recovered_master_clock_out <= recovered_level;
		end
	end

	// ****************************************
	// Pin output enables
	// ****************************************
	// Slave ports release their pins
	assign main_bit_clock_oe_n = ~misc_reg[`CCPC_MISC_MAIN_MASTER];
	assign main_frame_clock_oe_n = ~misc_reg[`CCPC_MISC_MAIN_MASTER];
	assign aux_bit_clock_oe_n = ~misc_reg[`CCPC_MISC_AUX_MASTER];
	assign aux_frame_clock_oe_n = ~misc_reg[`CCPC_MISC_AUX_MASTER];
	assign recovered_master_clock_oe_n = misc_reg[`CCPC_MISC_TRISTATE];

	// ****************************************
	// Sub-blocks
	// ****************************************
	ccpc_clk_sel u_clk_sel (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.clock_source_policy(ccpc_policy_t'(clock_reg[2:1])),
		.recovered_clock_divider(ccpc_div_t'(clock_reg[7:6])),
		.forced_pll_lock(clock_reg[`CCPC_CLK_FORCE_LOCK]),
		.pll_locked(pll_locked),
		.pll_clk_level(pll_clk_level),
		.osc_clk_level(osc_clk_level),
		.use_osc(use_osc),
		.mclk_level(mclk_level),
		.recovered_level(recovered_level)
	);

	ccpc_silence u_silence (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.sample_valid(audio_valid),
		.sample_data(audio_data),
		.silence(silence)
	);

endmodule : ccpc_top

//--- tb/ccpc_chk_sva.sv
// Purpose: Port-level checks of the clock and port control settings.
// Assumes: Zero-wait APB; byte address is four times the register index.
// Notes: Bound into ccpc_top; sees its ports only.
`include "ccpc_map.svh"
module ccpc_chk (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`CCPC_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic recovered_master_clock_oe_n,
	input wire logic interp_rolloff_sel,
	input wire logic highpass_hold,
	input wire logic main_bit_clock_oe_n,
	input wire logic main_frame_clock_oe_n,
	input wire logic aux_bit_clock_oe_n,
	input wire logic aux_frame_clock_oe_n,
	input wire logic [4:0] aux_word_bits,
	input wire logic [4:0] main_word_bits,
	input wire logic autodetect_en,
	input wire logic pll_frame_lock_sel
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****
	// Write decode
	// ****
	sequence s_wr(logic [7:0] idx);
		psel && penable && pwrite && pstrb[0] && paddr == {2'b00, idx, 2'b00};
	endsequence
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	// A field reaches its pin in the cycle after the write edge
	a_hiz_pin_follows: assert property (s_wr(`CCPC_IDX_MISC) |=>
		recovered_master_clock_oe_n == $past(pwdata[6])) else $error("tristate enable wrong");
	// A slow roll-off only ever starts from a write asking for it
	a_rolloff_cause: assert property ($rose(interp_rolloff_sel) |->
		$past(psel && penable && pwrite && pwdata[3])) else $error("roll-off rose alone");
	a_hp_hold_set: assert property (s_wr(`CCPC_IDX_MISC) |=>
		highpass_hold == $past(pwdata[2])) else $error("high-pass hold wrong");
	a_main_dir_pair: assert property (s_wr(`CCPC_IDX_MISC) |=>
		{main_bit_clock_oe_n, main_frame_clock_oe_n} == {2{!$past(pwdata[1])}})
		else $error("main port direction wrong");
	a_aux_dir_pair: assert property (s_wr(`CCPC_IDX_MISC) |=>
		{aux_bit_clock_oe_n, aux_frame_clock_oe_n} == {2{!$past(pwdata[0])}})
		else $error("aux port direction wrong");
	a_aux_word_len: assert property (s_wr(`CCPC_IDX_IFACE_FORMAT) |=>
		aux_word_bits == ($past(pwdata[1]) ? 5'h10 : 5'h18)) else $error("aux word length wrong");
	a_main_word_len: assert property (s_wr(`CCPC_IDX_IFACE_FORMAT) |=>
		main_word_bits == ($past(pwdata[0]) ? 5'h10 : 5'h18)) else $error("main word length wrong");
	a_force_autodet: assert property (s_wr(`CCPC_IDX_CLOCK) |=>
		autodetect_en != $past(pwdata[0])) else $error("auto-detect not tied to forced lock");
	a_frame_lock_sel: assert property (s_wr(`CCPC_IDX_CLOCK) |=>
		pll_frame_lock_sel == $past(pwdata[3])) else $error("frame lock select wrong");
endmodule : ccpc_chk
bind ccpc_top ccpc_chk chk_u (.*);

//--- tb/ccpc_far_end.sv
// Purpose: Far side of the block: PLL and oscillator clocks, external serial masters.
// Assumes: Clocks are sampled waveforms on core_clk.
// Notes: Periods are unrelated so the chosen source shows in edge counts.
module ccpc_far_end (
	input wire logic core_clk,
	output logic pll_clk_level,
	output logic osc_clk_level,
	output logic main_bit,
	output logic main_frame,
	output logic aux_bit,
	output logic aux_frame
);
	timeunit 1ns;
	timeprecision 1ps;
	int n = 0;
	// ****
	// Clock waveforms
	// ****
	initial begin
		{pll_clk_level, osc_clk_level, main_bit, main_frame, aux_bit, aux_frame} = 6'h00;
	end
	// External masters keep the codec port clocked while it is a slave
	always @(posedge core_clk) begin
		n <= n + 1;
		pll_clk_level <= (n % 20) < 10;
		osc_clk_level <= (n % 32) < 16;
		main_bit <= (n % 8) < 4;
		main_frame <= (n % 512) < 256;
		aux_bit <= (n % 12) < 6;
		aux_frame <= (n % 768) < 384;
	end
endmodule : ccpc_far_end

//--- tb/tb_top.sv
// Purpose: Self-checking bench of the clock and port control block.
// Assumes: Zero-wait APB; byte address four times the index.
// Notes: Expected values come from a small model kept in integers.
`include "ccpc_map.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk, arst_n, psel, penable, pwrite, pready, pslverr, err, prev;
	logic pll_locked, pll_clk_level, osc_clk_level, audio_valid;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, v;
	logic [31:0] seed = 32'h0000_000D;
	logic [3:0] pstrb;
	logic [7:0] pll_ratio_meas, held_settings;
	logic [2:0] pll_range_meas;
	logic [23:0] audio_data;
	logic [1:0] osc_clock_range;
	logic [4:0] aux_word_bits, main_word_bits;
	logic main_bit_clock_out, main_bit_clock_oe_n, main_frame_clock_out, main_frame_clock_oe_n;
	logic aux_bit_clock_out, aux_bit_clock_oe_n, aux_frame_clock_out, aux_frame_clock_oe_n;
	logic ext_adc_bit_clock, recovered_master_clock_out, recovered_master_clock_oe_n;
	logic interp_rolloff_sel, highpass_hold, pll_frame_lock_sel, autodetect_en;
	logic fmb, fmf, fab, faf, pb, pf;
	wire logic main_bit_clock_in, main_frame_clock_in, aux_bit_clock_in, aux_frame_clock_in;
	int bad_count = 0;
	int samples_checked = 0;
	int n, e, s, r, f;
	int pol[9] = '{0, 0, 1, 3, 2, 2, 2, 3, 0};
	int dv[9] = '{0, 0, 1, 2, 0, 0, 3, 3, 0};
	int frc[9] = '{0, 0, 0, 0, 0, 0, 0, 0, 1};
	int lck[9] = '{1, 0, 1, 1, 1, 0, 1, 0, 0};
	// Pin level: the block wins while it drives, else the far side
	assign main_bit_clock_in = main_bit_clock_oe_n ? fmb : main_bit_clock_out;
	assign main_frame_clock_in = main_frame_clock_oe_n ? fmf : main_frame_clock_out;
	assign aux_bit_clock_in = aux_bit_clock_oe_n ? fab : aux_bit_clock_out;
	assign aux_frame_clock_in = aux_frame_clock_oe_n ? faf : aux_frame_clock_out;
	ccpc_top dut_u (.*);
	ccpc_far_end far_u (.core_clk(core_clk), .pll_clk_level(pll_clk_level),
		.osc_clk_level(osc_clk_level), .main_bit(fmb), .main_frame(fmf), .aux_bit(fab),
		.aux_frame(faf));
	// ****
	// Helpers
	// ****
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : conclude
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		samples_checked++;
		if (got !== ex) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk
	// Bus cycle: request held until pready is seen high, bounded wait
	task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
		int k;
		k = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= {24'h00_0000, wd};
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 50) begin
			bad_count++;
			conclude();
		end
	endtask : apb
	task automatic wt(input int c);
		repeat (c) @(posedge core_clk);
	endtask : wt
	task automatic snd(input logic [23:0] d);
		@(posedge core_clk);
		audio_valid <= 1'b1;
		audio_data <= d;
		@(posedge core_clk);
		audio_valid <= 1'b0;
	endtask : snd
	// Free-running 200 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	// ****
	// Main sequence
	// ****
	initial begin
		{arst_n, psel, penable, pwrite, audio_valid} = 5'h00;
		{paddr, pwdata, audio_data, pll_ratio_meas, pll_range_meas} = 0;
		pstrb = 4'hF;
		pll_locked = 1'b1;
		repeat (5) @(posedge core_clk);
		arst_n <= 1'b1;
		apb(0, `CCPC_IDX_IFACE_FORMAT, 8'h00);
		chk("format_reset", 32'h0000_0040, rd);
		for (int i = 0; i < 4; i++) begin
			apb(1, `CCPC_IDX_IFACE_FORMAT, 8'h40 | i[7:0]);
			wt(1);
			chk("aux_bits", i[1] ? 24'h10 : 24'h18, aux_word_bits);
			chk("main_bits", i[0] ? 24'h10 : 24'h18, main_word_bits);
		end
		$display("test format done");
		for (int i = 0; i < 8; i++) begin
			v = xs();
			apb(1, `CCPC_IDX_MISC, v[7:0]);
			apb(0, `CCPC_IDX_MISC, 8'h00);
			chk("misc_read", v[7:0] & 8'hDF, rd);
			chk("hiz", v[6], recovered_master_clock_oe_n);
			chk("rolloff", v[3], interp_rolloff_sel);
			chk("hp_hold", v[2], highpass_hold);
			chk("main_oe", {2{~v[1]}}, {main_bit_clock_oe_n, main_frame_clock_oe_n});
			chk("aux_oe", {2{~v[0]}}, {aux_bit_clock_oe_n, aux_frame_clock_oe_n});
		end
		apb(1, `CCPC_IDX_MISC, 8'h00);
		apb(1, `CCPC_IDX_RATIO, 8'hFF);
		apb(0, 8'h3F, 8'h00);
		chk("unmapped_err", 1, err);
		$display("test misc done");
		for (int i = 0; i < 8; i++) begin
			v = xs();
			if (v[0]) begin
				v[2:1] = 2'b00;
			end
			pll_ratio_meas <= v[15:8];
			pll_range_meas <= v[18:16];
			apb(1, `CCPC_IDX_CLOCK, v[7:0]);
			apb(0, `CCPC_IDX_RATIO, 8'h00);
			chk("ratio", v[0] ? 8'h00 : v[15:8], rd);
			apb(0, `CCPC_IDX_RX_STATUS, 8'h00);
			chk("pll_range", v[0] ? 3'h7 : v[18:16], rd[2:0]);
			chk("autodetect", !v[0], autodetect_en);
			chk("frame_lock", v[3], pll_frame_lock_sel);
			chk("osc_range", v[5:4], osc_clock_range);
		end
		$display("test clock fields done");
		// Source model: s is the master clock source, r what feeds the recovered clock
		s = 0;
		for (int k = 0; k < 9; k++) begin
			pll_locked <= lck[k][0];
			apb(1, `CCPC_IDX_CLOCK, {dv[k][1:0], 3'b000, pol[k][1:0], frc[k][0]});
			case (pol[k])
				0: s = 0;
				1: s = 1;
				2: s = lck[k] ? s : 1;
				default: s = !lck[k];
			endcase
			r = (pol[k] == 0 && !lck[k] && !frc[k]) ? 1 : s;
			wt(8);
			n = 0;
			prev = recovered_master_clock_out;
			repeat (640) begin
				@(posedge core_clk);
				n += (recovered_master_clock_out && !prev) ? 1 : 0;
				prev = recovered_master_clock_out;
			end
			e = 640 / (r ? 32 : 20);
			e = dv[k] == 1 ? e / 2 : dv[k] == 2 ? e / 4 : dv[k] == 3 ? e * 2 : e;
			chk("recovered_master_clock_out_edges", e, (n >= e - 2 && n <= e + 2) ? e : n);
			apb(0, `CCPC_IDX_RX_STATUS, 8'h00);
			if (!(pol[k] == 0 && !lck[k])) begin
				chk("active_clk", s, rd[3]);
			end
		end
		apb(1, `CCPC_IDX_CLOCK, 8'h00);
		$display("test clock source done");
		// External ADC bit clock source and master port clocks, all four settings
		pll_locked <= 1'b1;
		f = 0;
		for (int m = 0; m < 4; m++) begin
			apb(1, `CCPC_IDX_MISC, {m[1], 5'b00000, m[0], m[0]});
			wt(8);
			n = 0;
			r = 0;
			prev = ext_adc_bit_clock;
			pb = main_bit_clock_out;
			pf = main_frame_clock_out;
			repeat (640) begin
				@(posedge core_clk);
				n += (ext_adc_bit_clock && !prev) ? 1 : 0;
				r += (main_bit_clock_out && !pb) ? 1 : 0;
				f += (main_frame_clock_out && !pf) ? 1 : 0;
				prev = ext_adc_bit_clock;
				pb = main_bit_clock_out;
				pf = main_frame_clock_out;
			end
			e = m[0] ? 8 : m[1] ? 80 : 53;
			chk("ext_adc_edges", e, (n >= e - 2 && n <= e + 2) ? e : n);
			chk("port_bit_edges", 8, (r >= 6 && r <= 10) ? 8 : r);
		end
		chk("port_frame_edges", 2, (f >= 1 && f <= 3) ? 2 : f);
		$display("test port clocks done");
		v = xs() | 32'h0000_0080;
		apb(1, `CCPC_IDX_MISC, 8'h10);
		apb(1, `CCPC_IDX_PENDING, v[7:0]);
		wt(4);
		chk("frozen", 8'h00, held_settings);
		apb(1, `CCPC_IDX_MISC, 8'h00);
		wt(2);
		chk("applied", v[7:0], held_settings);
		apb(0, `CCPC_IDX_LIVE, 8'h00);
		chk("live_read", v[7:0], rd);
		$display("test update hold done");
		v = xs();
		snd(v[23:0] | 24'h00_0001);
		repeat (1547) snd(24'h00_0000);
		apb(0, `CCPC_IDX_RX_STATUS, 8'h00);
		chk("silence_short", 0, rd[7]);
		snd(24'h00_0000);
		apb(0, `CCPC_IDX_RX_STATUS, 8'h00);
		chk("silence_set", 1, rd[7]);
		snd(24'h00_0100);
		apb(0, `CCPC_IDX_RX_STATUS, 8'h00);
		chk("silence_clear", 0, rd[7]);
		$display("test silence done");
		conclude();
	end
endmodule : tb_top
